//--- hdl/iopm_pkg.sv
// package: constants, types and helpers of the io pair mirroring block
package iopm_pkg;
	// ==========================================
	// sizes
	localparam int IOPM_ENTRIES = 12;
	localparam int IOPM_CHANNELS = 16;
	localparam int IOPM_ADDR_W = 12;
	// ==========================================
	// register map: per entry block of eight words
	localparam logic [11:0] IOPM_GLOBAL_BASE = 12'h180;
	localparam logic [11:0] IOPM_OFS_DI_STATE = 12'h180;
	localparam logic [11:0] IOPM_OFS_DO_STATE = 12'h184;
	localparam logic [2:0] IOPM_REG_CTRL = 3'h0;
	localparam logic [2:0] IOPM_REG_PEER_IP = 3'h1;
	localparam logic [2:0] IOPM_REG_PEER_PORT = 3'h2;
	localparam logic [2:0] IOPM_REG_SCAN = 3'h3;
	localparam logic [2:0] IOPM_REG_BASES = 3'h4;
	localparam logic [2:0] IOPM_REG_STATUS = 3'h5;
	// control word fields
	localparam int IOPM_CTRL_MODE_LSB = 0;
	localparam int IOPM_CTRL_UDP_BIT = 4;
	localparam int IOPM_CTRL_COUNT_LSB = 8;
	localparam int IOPM_CTRL_UNIT_LSB = 16;
	localparam int IOPM_BASES_OUT_LSB = 8;
	// ==========================================
	// reset values and limits
	localparam logic [4:0] IOPM_COUNT_RST = 5'h00;
	localparam logic [4:0] IOPM_COUNT_MAX = 5'h10;
	localparam logic [7:0] IOPM_UNIT_RST = 8'h01;
	localparam logic [7:0] IOPM_UNIT_MAX = 8'hF7;
	localparam logic [15:0] IOPM_PORT_RST = 16'h01F6;
	localparam logic [31:0] IOPM_SCAN_RST = 32'h000003E8;
	localparam logic [31:0] IOPM_SCAN_MIN = 32'h000003E8;
	localparam logic [1:0] IOPM_RESP_OKAY = 2'h0;
	localparam logic [1:0] IOPM_RESP_SLVERR = 2'h2;
	// ==========================================
	// timing: millisecond tick
	localparam int IOPM_CLK_PERIOD_PS = 8000;
	localparam int IOPM_TICK_NS = 1000000;
	localparam int IOPM_MS_CYCLES = IOPM_TICK_NS * 1000 / IOPM_CLK_PERIOD_PS;
	// ==========================================
	// types
	typedef enum logic [1:0] {
		IOPM_MODE_DISABLED = 2'b00,
		IOPM_MODE_REMOTE_READ = 2'b01,
		IOPM_MODE_LOCAL_SEND = 2'b10
	} iopm_mode_t;
	typedef enum logic [1:0] {
		IOPM_ENG_IDLE = 2'b00,
		IOPM_ENG_REQ = 2'b01,
		IOPM_ENG_WAIT = 2'b11
	} iopm_eng_t;
	typedef struct packed {
		iopm_mode_t mode;
		logic udp;
		logic [4:0] count;
		logic [7:0] unit;
		logic [31:0] ip;
		logic [15:0] port;
		logic [31:0] scan;
		logic [7:0] in_base;
		logic [7:0] out_base;
	} iopm_entry_t;
	// ==========================================
	// local channel window starting at base, count wide
	function automatic logic [15:0] iopm_window(input logic [7:0] base, input logic [4:0] cnt);
		logic [15:0] m;
		m = '0;
		for (int j = 0; j < IOPM_CHANNELS; j++)
			m[j] = (j >= int'(base)) && (j - int'(base) < int'(cnt));
		return m;
	endfunction
endpackage

//--- hdl/iopm_tick.sv
// millisecond tick generator
`timescale 1ns/1ps
module iopm_tick import iopm_pkg::*; #(
	parameter int unsigned CYCLES = IOPM_MS_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// one-cycle pulse per period
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} iopm_tick_state_t;
	iopm_tick_state_t q, d;

	// count cycles, pulse at wrap
	always_comb
	begin
		d = q;
		d.tick = 1'b0;
		if (!aresetn)
			d = '0;
		else if (q.cnt >= CYCLES - 1)
		begin
			d.cnt = '0;
			d.tick = 1'b1;
		end
		else
			d.cnt = q.cnt + 32'h1;
	end

	always_ff @(posedge aclk)
		q <= d;

	assign tick = q.tick;
endmodule

//--- hdl/iopm_axil.sv
// axi4-lite slave front end of the register file
`timescale 1ns/1ps
module iopm_axil import iopm_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address and data
	input wire logic [IOPM_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address and data
	input wire logic [IOPM_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register access toward the core
	output logic wr_en,
	output logic [IOPM_ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic rd_en,
	output logic [IOPM_ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	typedef struct packed {
		logic aw_have;
		logic [IOPM_ADDR_W-1:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} iopm_axil_state_t;
	iopm_axil_state_t q, d;

	// channel handshakes; address and data in either order
	always_comb
	begin
		d = q;
		wr_en = 1'b0;
		rd_en = 1'b0;
		if (!aresetn)
			d = '0;
		else
		begin
			if (awvalid && q.awready)
			begin
				d.aw_have = 1'b1;
				d.awaddr = awaddr;
			end
			if (wvalid && q.wready)
			begin
				d.w_have = 1'b1;
				d.wdata = wdata;
				d.wstrb = wstrb;
			end
			if (q.aw_have && q.w_have && !q.bvalid)
			begin
				wr_en = 1'b1;
				d.bvalid = 1'b1;
				d.bresp = wr_ok ? IOPM_RESP_OKAY : IOPM_RESP_SLVERR;
				d.aw_have = 1'b0;
				d.w_have = 1'b0;
			end
			if (q.bvalid && bready)
				d.bvalid = 1'b0;
			if (arvalid && q.arready)
			begin
				rd_en = 1'b1;
				d.rvalid = 1'b1;
				d.rdata = rd_ok ? rd_data : 32'h0;
				d.rresp = rd_ok ? IOPM_RESP_OKAY : IOPM_RESP_SLVERR;
			end
			if (q.rvalid && rready)
				d.rvalid = 1'b0;
			d.awready = !d.aw_have && !d.bvalid;
			d.wready = !d.w_have && !d.bvalid;
			d.arready = !d.rvalid;
		end
	end

	always_ff @(posedge aclk)
		q <= d;

	// outputs from the state; rd_addr straight from araddr
	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign wr_addr = q.awaddr;
	assign wr_data = q.wdata;
	assign wr_strb = q.wstrb;
	assign rd_addr = araddr;
endmodule

//--- hdl/iopm_top.sv
// io pair mirroring: entry table, scan timers and client request engine
//
// Overview of operation
// RULE1 - disabled entry issues no client requests; device stays server only
// RULE2 - remote-read mode reads remote inputs and drives mapped local outputs
// RULE3 - local-send mode writes mapped local input states to remote outputs
// RULE4 - client activity needs nonzero mapped count and a client mode
// RULE5 - mapped count accepts 1 to 16, zero disables, resets to zero
// RULE6 - remote-read repeats read and output update once per scan period
// RULE7 - local-send sends update whenever a mapped local input changes
// RULE8 - local-send forces a refresh write when a scan period passes unchanged
// RULE9 - scan period in milliseconds, at least 1000, resets to 1000
// RULE10 - unit identifier 1 to 247, resets to 1, placed in every request
// RULE11 - peer address resets to zero, port resets to 502, both target requests
// RULE12 - input and output base indexes; local or remote role swaps with mode
// RULE13 - udp only in local-send mode, remote-read always tcp, resets to tcp
// RULE14 - twelve independent entries with own mode, timer and configuration
// RULE15 - channel k maps source base plus k to destination base plus k
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module iopm_top import iopm_pkg::*; #(
	parameter int unsigned MS_CYCLES = IOPM_MS_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite register bus
	input wire logic [IOPM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [IOPM_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// local digital channels
	input wire logic [IOPM_CHANNELS-1:0] local_di,
	output logic [IOPM_CHANNELS-1:0] local_do,
	// client request to the transaction engine
	output logic req_valid,
	input wire logic req_ready,
	output logic [3:0] req_entry,
	output logic req_write,
	output logic req_udp,
	output logic [31:0] req_peer_ip_address,
	output logic [15:0] req_peer_port,
	output logic [7:0] req_unit_identifier,
	output logic [15:0] req_addr,
	output logic [4:0] req_count,
	output logic [15:0] req_wdata,
	// answer from the transaction engine
	input wire logic resp_valid,
	input wire logic resp_ok,
	input wire logic [15:0] resp_data
);
	typedef struct packed {
		iopm_entry_t [IOPM_ENTRIES-1:0] ent;
		logic [IOPM_ENTRIES-1:0][31:0] timer;
		logic [IOPM_ENTRIES-1:0] pend;
		logic [15:0] di_meta;
		logic [15:0] di_sync;
		logic [15:0] di_prev;
		logic [15:0] dout;
		iopm_eng_t eng;
		logic [3:0] cur;
		logic [3:0] rr;
		logic req_valid;
		logic req_write;
		logic req_udp;
		logic [31:0] req_ip;
		logic [15:0] req_port;
		logic [7:0] req_unit;
		logic [15:0] req_addr;
		logic [4:0] req_count;
		logic [15:0] req_wdata;
	} iopm_top_state_t;
	iopm_top_state_t q, d;

	logic tick;
	logic wr_en, wr_ok, rd_en, rd_ok;
	logic [IOPM_ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic [32:0] rd_word, wr_word;
	logic [IOPM_ENTRIES-1:0] act_w, hit_w;

	// ==========================================
	// sub blocks
	iopm_tick #(.CYCLES(MS_CYCLES)) u_tick (.aclk(aclk), .aresetn(aresetn), .tick(tick));

	iopm_axil u_axil (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
		.wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
		.bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
		.araddr(s_axi_araddr), .arvalid(s_axi_arvalid), .arready(s_axi_arready),
		.rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb), .wr_ok(wr_ok),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
	);

	// ==========================================
	// register read decode, {ok, data}
	function automatic logic [32:0] read_word(input logic [IOPM_ADDR_W-1:0] a);
		logic [3:0] i;
		logic [2:0] sel;
		logic [31:0] v;
		logic ok;
		i = a[8:5];
		sel = a[4:2];
		v = '0;
		ok = 1'b1;
		if (a < IOPM_GLOBAL_BASE)
		begin
			if (sel == IOPM_REG_CTRL)
			begin
				v[IOPM_CTRL_MODE_LSB +: 2] = q.ent[i].mode;
				v[IOPM_CTRL_UDP_BIT] = q.ent[i].udp;
				v[IOPM_CTRL_COUNT_LSB +: 5] = q.ent[i].count;
				v[IOPM_CTRL_UNIT_LSB +: 8] = q.ent[i].unit;
			end
			else if (sel == IOPM_REG_PEER_IP)
				v = q.ent[i].ip;
			else if (sel == IOPM_REG_PEER_PORT)
				v[15:0] = q.ent[i].port;
			else if (sel == IOPM_REG_SCAN)
				v = q.ent[i].scan;
			else if (sel == IOPM_REG_BASES)
				v[15:0] = {q.ent[i].out_base, q.ent[i].in_base};
			else if (sel == IOPM_REG_STATUS)
				v[2:0] = {q.eng != IOPM_ENG_IDLE && q.cur == i, q.pend[i], act_w[i]};
			else
				ok = 1'b0;
		end
		else if (a[11:2] == IOPM_OFS_DI_STATE[11:2])
			v[15:0] = q.di_sync;
		else if (a[11:2] == IOPM_OFS_DO_STATE[11:2])
			v[15:0] = q.dout;
		else
			ok = 1'b0;
		return {ok, v};
	endfunction

	// extract count bits of vec from base, zero beyond the local channels
	function automatic logic [15:0] gather(input logic [15:0] vec, input logic [7:0] base, input logic [4:0] cnt);
		logic [15:0] r;
		r = '0;
		for (int k = 0; k < IOPM_CHANNELS; k++)
			if (k < int'(cnt) && k + int'(base) < IOPM_CHANNELS)
				r[k] = vec[k + int'(base)];
		return r;
	endfunction

	// bus decode; a process, so that table and status changes re-run the decode
	always_comb
	begin
		rd_word = read_word(rd_addr);
		wr_word = read_word(wr_addr);
	end
	assign rd_data = rd_word[31:0];
	assign rd_ok = rd_word[32];
	assign wr_ok = wr_word[32];

	// entry activity and change hits
	always_comb
	begin
		for (int i = 0; i < IOPM_ENTRIES; i++)
		begin
			act_w[i] = q.ent[i].mode != IOPM_MODE_DISABLED && q.ent[i].count != 5'h00; // see RULE1 see RULE4
			hit_w[i] = act_w[i] && q.ent[i].mode == IOPM_MODE_LOCAL_SEND
				&& |((q.di_sync ^ q.di_prev) & iopm_window(q.ent[i].in_base, q.ent[i].count)); // see RULE7
		end
	end

	// ==========================================
	// next state
	always_comb
	begin
		logic [31:0] nv, m;
		logic [3:0] wi, pick, idx;
		logic found;
		iopm_entry_t e;
		logic [15:0] win;
		nv = '0;
		m = '0;
		wi = '0;
		pick = '0;
		idx = '0;
		found = 1'b0;
		win = '0;
		e = q.ent[q.cur];
		d = q;
		if (!aresetn)
		begin
			d = '0;
			for (int i = 0; i < IOPM_ENTRIES; i++)
			begin
				d.ent[i].mode = IOPM_MODE_DISABLED;
				d.ent[i].count = IOPM_COUNT_RST; // see RULE5
				d.ent[i].unit = IOPM_UNIT_RST; // see RULE10
				d.ent[i].port = IOPM_PORT_RST; // see RULE11
				d.ent[i].scan = IOPM_SCAN_RST; // see RULE9
				d.ent[i].udp = 1'b0; // see RULE13
			end
		end
		else
		begin
			// input synchroniser and change reference
			d.di_meta = local_di;
			d.di_sync = q.di_meta;
			d.di_prev = q.di_sync;
			// register writes, byte lanes merged into the old word
			if (wr_en && wr_ok && wr_addr < IOPM_GLOBAL_BASE)
			begin
				for (int b = 0; b < 4; b++)
					m[b*8 +: 8] = {8{wr_strb[b]}};
				nv = (wr_word[31:0] & ~m) | (wr_data & m);
				wi = wr_addr[8:5];
				if (wr_addr[4:2] == IOPM_REG_CTRL)
				begin
					d.ent[wi].mode = (nv[IOPM_CTRL_MODE_LSB +: 2] == 2'b11) ? IOPM_MODE_DISABLED
						: iopm_mode_t'(nv[IOPM_CTRL_MODE_LSB +: 2]);
					d.ent[wi].udp = nv[IOPM_CTRL_UDP_BIT];
					d.ent[wi].count = (nv[IOPM_CTRL_COUNT_LSB +: 5] > IOPM_COUNT_MAX) ? IOPM_COUNT_MAX
						: nv[IOPM_CTRL_COUNT_LSB +: 5]; // see RULE5
					if (nv[IOPM_CTRL_UNIT_LSB +: 8] != 8'h00 && nv[IOPM_CTRL_UNIT_LSB +: 8] <= IOPM_UNIT_MAX)
						d.ent[wi].unit = nv[IOPM_CTRL_UNIT_LSB +: 8]; // see RULE10
				end
				else if (wr_addr[4:2] == IOPM_REG_PEER_IP)
					d.ent[wi].ip = nv; // see RULE11
				else if (wr_addr[4:2] == IOPM_REG_PEER_PORT)
					d.ent[wi].port = nv[15:0]; // see RULE11
				else if (wr_addr[4:2] == IOPM_REG_SCAN)
					d.ent[wi].scan = (nv < IOPM_SCAN_MIN) ? IOPM_SCAN_MIN : nv; // see RULE9
				else if (wr_addr[4:2] == IOPM_REG_BASES)
				begin
					d.ent[wi].in_base = nv[7:0]; // see RULE12
					d.ent[wi].out_base = nv[IOPM_BASES_OUT_LSB +: 8];
				end
			end
			// request engine, round robin over pending entries
			case (q.eng)
				IOPM_ENG_IDLE:
				begin
					for (int i = 0; i < IOPM_ENTRIES; i++)
					begin
						idx = 4'((int'(q.rr) + i) % IOPM_ENTRIES);
						if (!found && q.pend[idx])
						begin
							found = 1'b1;
							pick = idx;
						end
					end
					if (found)
					begin
						e = q.ent[pick];
						d.pend[pick] = 1'b0;
						d.cur = pick;
						d.rr = (pick == 4'(IOPM_ENTRIES - 1)) ? 4'h0 : pick + 4'h1;
						d.eng = IOPM_ENG_REQ;
						d.req_valid = 1'b1;
						d.req_write = e.mode == IOPM_MODE_LOCAL_SEND; // see RULE2 see RULE3
						d.req_udp = e.mode == IOPM_MODE_LOCAL_SEND && e.udp; // see RULE13
						d.req_ip = e.ip; // see RULE11
						d.req_port = e.port;
						d.req_unit = e.unit; // see RULE10
						d.req_count = e.count;
						// remote side: input base when reading, output base when sending
						d.req_addr = {8'h00, d.req_write ? e.out_base : e.in_base}; // see RULE12
						d.req_wdata = d.req_write ? gather(q.di_sync, e.in_base, e.count) : 16'h0; // see RULE15
					end
				end
				IOPM_ENG_REQ:
					if (req_ready)
					begin
						d.req_valid = 1'b0;
						d.eng = IOPM_ENG_WAIT;
					end
				IOPM_ENG_WAIT:
					if (resp_valid)
					begin
						// remote inputs land on local outputs from the output base
						if (!q.req_write && resp_ok)
						begin
							win = iopm_window(e.out_base, q.req_count);
							for (int j = 0; j < IOPM_CHANNELS; j++)
								if (win[j])
									d.dout[j] = resp_data[j - int'(e.out_base)]; // see RULE2 see RULE15
						end
						d.eng = IOPM_ENG_IDLE;
					end
				default:
					d.eng = IOPM_ENG_IDLE;
			endcase
			// scan timers and pending flags; a new event beats the clear above
			for (int i = 0; i < IOPM_ENTRIES; i++)
			begin
				if (!act_w[i])
				begin
					d.timer[i] = '0;
					d.pend[i] = 1'b0; // see RULE1 see RULE4
				end
				else
				begin
					if (tick)
					begin
						if (q.timer[i] >= q.ent[i].scan - 32'h1)
						begin
							d.timer[i] = '0;
							d.pend[i] = 1'b1; // see RULE6 see RULE8 see RULE14
						end
						else
							d.timer[i] = q.timer[i] + 32'h1;
					end
					if (hit_w[i])
					begin
						d.timer[i] = '0;
						d.pend[i] = 1'b1; // see RULE7
					end
				end
			end
		end
	end

	always_ff @(posedge aclk)
		q <= d;

	// outputs
	assign local_do = q.dout;
	assign req_valid = q.req_valid;
	assign req_entry = q.cur;
	assign req_write = q.req_write;
	assign req_udp = q.req_udp;
	assign req_peer_ip_address = q.req_ip;
	assign req_peer_port = q.req_port;
	assign req_unit_identifier = q.req_unit;
	assign req_addr = q.req_addr;
	assign req_count = q.req_count;
	assign req_wdata = q.req_wdata;

	// ==========================================
	// assertions
	sequence s_req_stall;
		req_valid && !req_ready;
	endsequence
	sequence s_req_held;
		req_valid && $stable(req_addr) && $stable(req_entry);
	endsequence
	property p_inactive_idle;
		@(posedge aclk) disable iff (!aresetn) !act_w[0] |=> !q.pend[0];
	endproperty
	a_inactive_idle: assert property (p_inactive_idle) else $error("inactive entry pending"); // see RULE1
	property p_count_range;
		@(posedge aclk) disable iff (!aresetn) $rose(req_valid) |-> req_count != 5'h00 && req_count <= 5'h10;
	endproperty
	a_count_range: assert property (p_count_range) else $error("bad mapped count"); // see RULE4
	property p_read_tcp;
		@(posedge aclk) disable iff (!aresetn) req_valid && !req_write |-> !req_udp;
	endproperty
	a_read_tcp: assert property (p_read_tcp) else $error("udp on remote read"); // see RULE13
	property p_unit_range;
		@(posedge aclk) disable iff (!aresetn) req_valid |-> req_unit_identifier inside {[8'h01:8'hF7]};
	endproperty
	a_unit_range: assert property (p_unit_range) else $error("unit id out of range"); // see RULE10
	property p_scan_floor;
		@(posedge aclk) disable iff (!aresetn) ##1 q.ent[0].scan >= IOPM_SCAN_MIN && q.ent[11].scan >= IOPM_SCAN_MIN;
	endproperty
	a_scan_floor: assert property (p_scan_floor) else $error("scan period below floor"); // see RULE9
	property p_timer_bound;
		@(posedge aclk) disable iff (!aresetn) act_w[1] |=> q.timer[1] < q.ent[1].scan;
	endproperty
	a_timer_bound: assert property (p_timer_bound) else $error("scan timer overran"); // see RULE6
	property p_change_pends;
		@(posedge aclk) disable iff (!aresetn) hit_w[2] |=> q.pend[2] || (req_valid && req_entry == 4'h2);
	endproperty
	a_change_pends: assert property (p_change_pends) else $error("input change lost"); // see RULE7
	property p_req_stable;
		@(posedge aclk) disable iff (!aresetn) s_req_stall |=> s_req_held;
	endproperty
	a_req_stable: assert property (p_req_stable) else $error("request dropped while stalled"); // see RULE3
	property p_expire_pends;
		@(posedge aclk) disable iff (!aresetn) tick && act_w[2] && q.timer[2] == q.ent[2].scan - 32'h1
			|=> q.pend[2] || (req_valid && req_entry == 4'h2);
	endproperty
	a_expire_pends: assert property (p_expire_pends) else $error("scan expiry lost"); // see RULE8
endmodule

//--- dv/iopm_peer_model.sv
// remote modbus device model answering client requests
`timescale 1ns/1ps
module iopm_peer_model import iopm_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request handshake
	input wire logic req_valid,
	output logic req_ready,
	// answer
	output logic resp_valid,
	output logic resp_ok,
	output logic [15:0] resp_data,
	// model controls
	input wire logic [15:0] remote_di,
	input wire logic [3:0] delay
);
	int n_req = 0;
	// ==========================================
	// take one request, answer after the chosen delay
	initial
	begin
		req_ready = 0;
		resp_valid = 0;
		resp_ok = 0;
		resp_data = 16'h5A5A;
		forever
		begin
			@(posedge aclk);
			if (aresetn && req_valid)
			begin
				repeat (delay) @(posedge aclk);
				req_ready <= 1;
				@(posedge aclk);
				req_ready <= 0;
				repeat (delay) @(posedge aclk);
				resp_valid <= 1;
				resp_ok <= 1;
				resp_data <= remote_di;
				@(posedge aclk);
				resp_valid <= 0;
				resp_ok <= 0;
				// data lines show garbage outside the answer
				resp_data <= ~remote_di;
				n_req++;
			end
		end
	end
endmodule

//--- dv/tb.sv
// self-checking bench of the io pair mirroring block
`timescale 1ns/1ps
module tb import iopm_pkg::*;;
	localparam int MS = 10;
	localparam int PER = 1000 * MS;
	logic aclk = 0;
	logic aresetn = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF, delay = 4'h0, req_entry;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [15:0] local_di = '0, local_do, remote_di = 16'h00F5;
	logic req_valid, req_ready, req_write, req_udp, resp_valid, resp_ok;
	logic [31:0] req_peer_ip_address;
	logic [15:0] req_peer_port, req_addr, req_wdata, resp_data;
	logic [7:0] req_unit_identifier;
	logic [4:0] req_count;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	// ==========================================
	// design and far side
	iopm_top #(.MS_CYCLES(MS)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .local_di, .local_do, .req_valid, .req_ready, .req_entry,
		.req_write, .req_udp, .req_peer_ip_address, .req_peer_port, .req_unit_identifier, .req_addr,
		.req_count, .req_wdata, .resp_valid, .resp_ok, .resp_data);
	iopm_peer_model u_peer (.aclk, .aresetn, .req_valid, .req_ready, .resp_valid, .resp_ok, .resp_data,
		.remote_di, .delay);
	// ==========================================
	// clock and hang guard
	initial
		forever #4 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			failures++;
			end_of_test();
		end
	end
	// ==========================================
	// compare, bus cycles and waits
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
			rs = s_axi_bresp;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
	endtask
	task automatic axr(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 0;
			rs = s_axi_rresp;
			rd = s_axi_rdata;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		axw(a, d);
		chk("bresp", IOPM_RESP_OKAY, rs);
	endtask
	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		axr(a);
		chk(what, exp, rd);
	endtask
	task automatic wait_req(output int c);
		c = 0;
		do
		begin
			@(posedge aclk);
			c++;
		end while (!(req_valid === 1'b1 && req_ready === 1'b1));
	endtask
	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================
	// test sequence
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		// reset values, clamps and an unmapped place
		rdc("ctrl", 12'h000, 32'h00010000);
		rdc("ip", 12'h004, 32'h00000000);
		rdc("port", 12'h008, 32'h000001F6);
		rdc("scan", 12'h00C, 32'h000003E8);
		rdc("bases", 12'h010, 32'h00000000);
		axr(12'h1A0);
		chk("rresp", IOPM_RESP_SLVERR, rs);
		axw(12'h1A0, 32'h0000FFFF);
		chk("bresp", IOPM_RESP_SLVERR, rs);
		wr(12'h000, 32'h00001400);
		rdc("clamp", 12'h000, 32'h00011000);
		wr(12'h00C, 32'h000001F4);
		rdc("scan min", 12'h00C, 32'h000003E8);
		wr(12'h000, 32'h00000003);
		rdc("mode 3", 12'h000, 32'h00010000);
		$display("test registers done");
		// client mode with no channels, channels with no client mode
		wr(12'h000, 32'h00010001);
		wr(12'h060, 32'h00010500);
		repeat (PER + 1000) @(posedge aclk);
		chk("idle reqs", 0, u_peer.n_req);
		$display("test disabled done");
		// remote read on entry 1, transport bit set but ignored
		wr(12'h024, 32'h0A000002);
		wr(12'h028, 32'h00001388);
		wr(12'h030, 32'h00000302);
		wr(12'h020, 32'h00050411);
		wait_req(n);
		chk("rd write", 0, req_write);
		chk("rd udp", 0, req_udp);
		chk("rd entry", 1, req_entry);
		chk("rd unit", 5, req_unit_identifier);
		chk("rd ip", 32'h0A000002, req_peer_ip_address);
		chk("rd port", 16'h1388, req_peer_port);
		chk("rd base", 2, req_addr);
		chk("rd count", 4, req_count);
		repeat (8) @(posedge aclk);
		chk("do", 16'h0028, local_do);
		remote_di <= 16'h000A;
		wait_req(n);
		chk("rd period", 1, n >= PER - MS - 20 && n <= PER + MS + 40);
		repeat (8) @(posedge aclk);
		chk("do again", 16'h0050, local_do);
		rdc("do state", 12'h184, 32'h00000050);
		wr(12'h020, 32'h00050000);
		$display("test remote read done");
		// local send on entry 2 with a slow far side
		delay <= 4'h3;
		local_di <= 16'h0002;
		wr(12'h050, 32'h00000401);
		wr(12'h040, 32'h00070312);
		repeat (60) @(posedge aclk);
		local_di <= 16'h000E;
		wait_req(n);
		chk("send delay", 1, n < 40);
		chk("wr write", 1, req_write);
		chk("wr udp", 1, req_udp);
		chk("wr unit", 7, req_unit_identifier);
		chk("wr base", 4, req_addr);
		chk("wr data", 16'h0007, req_wdata);
		local_di <= 16'h010E;
		wait_req(n);
		chk("refresh", 1, n >= PER - MS - 20 && n <= PER + MS + 40);
		chk("refresh data", 16'h0007, req_wdata);
		rdc("di state", 12'h180, 32'h0000010E);
		$display("test local send done");
		end_of_test();
	end
endmodule
